// ==== src/dslc_pkg.sv ====
/*
 Constants and types of the serial load and clear port of a quad converter.
 Assumes a 25 MHz core clock; shared by the port and its bench.
*/
package dslc_pkg;
    // Core clock rate
    localparam int unsigned CLK_HZ       = 25_000_000;
    // Channels and code width
    localparam int unsigned NCH          = 4;
    localparam int unsigned DW           = 16;
    // Frame length and field positions, first bit sent is bit 23
    localparam int unsigned FRAME_BITS   = 24;
    localparam int unsigned ADDR_HI      = 23;
    localparam int unsigned ADDR_LO      = 22;
    localparam int unsigned CMD_HI       = 21;
    localparam int unsigned CMD_LO       = 20;
    localparam int unsigned CH_HI        = 19;
    localparam int unsigned CH_LO        = 18;
    localparam int unsigned DATA_HI      = 15;
    // Reset values
    localparam logic [15:0] CODE_RST     = 16'h0000;
    localparam logic [15:0] CLR_CODE_RST = 16'h0000;
    localparam logic [3:0]  CLR_EN_RST   = 4'h0;
    // Pin levels at reset: frame, serial clock and load idle high
    localparam logic [9:0]  PIN_RST      = 10'h00b;
    // Idle time before the alert, in microseconds, and in core cycles
    localparam int unsigned WDOG_TIME_US = 1000;
    localparam int unsigned WDOG_CYC     = WDOG_TIME_US * (CLK_HZ / 1_000_000);

    // Frame commands
    typedef enum logic [1:0] {
        CMD_DATA,
        CMD_CLR_CODE,
        CMD_CLR_EN,
        CMD_READ
    } dslc_cmd_t;

    // Frame state
    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } dslc_state_t;
endpackage : dslc_pkg

// ==== src/dslc_sync.sv ====
/*
 Three-stage synchroniser for pin inputs; a change is taken once the
 second and third stages agree. Assumes asynchronous inputs.
*/
`timescale 1ns/1ns
module dslc_sync #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RV = '0
) (
    // Clock, reset and enable
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    // Pins and clean levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] lvl_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] nxt_lvl;

    // The clean level moves only when every bit of the second and third stages agrees
    assign nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_out;

    // Stage chain; first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_ff   <= RV;
            s2_ff   <= RV;
            s3_ff   <= RV;
            lvl_out <= RV;
        end else if (ce) begin
            s1_ff   <= pin_in;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            lvl_out <= nxt_lvl;
        end
    end
endmodule : dslc_sync

// ==== src/dslc_port.sv ====
/*
 Serial load and clear port of a quad current-output converter: framed
 serial input with readback, per-channel input and output registers,
 load strobe, clear edge, idle alert and open-drain fault.
 Assumes all pins are asynchronous to core_clk and the serial clock is
 well below a quarter of the core clock rate.
*/
`timescale 1ns/1ns
module dslc_port #(
    parameter int unsigned WDOG_CYC = dslc_pkg::WDOG_CYC
) (
    // Clock, reset, enable
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire logic                   ce,
    // Serial link pins
    input  wire logic                   frame_sync_n,
    input  wire logic                   serial_clk,
    input  wire logic                   serial_in,
    output logic                        serial_out,
    output logic                        serial_out_oe,
    // Control pins
    input  wire logic                   load_outputs_n,
    input  wire logic                   clear_in,
    input  wire logic                   board_address_bit0,
    input  wire logic                   board_address_bit1,
    // Analog fault monitors
    input  wire logic                   open_circuit,
    input  wire logic                   short_circuit,
    input  wire logic                   over_temp,
    // Status pins
    output logic                        alert,
    output logic                        fault_n_o,
    output logic                        fault_n_oe,
    // Channel output codes
    output logic [3:0][15:0]            dac_code
);
    localparam int unsigned NS = 10;

    logic [NS-1:0]        pins;
    logic [NS-1:0]        lvl;
    logic [NS-1:0]        lvl_d_ff;
    dslc_pkg::dslc_state_t st_ff;
    dslc_pkg::dslc_state_t nxt_st;
    logic [23:0]          shreg_ff;
    logic [4:0]           cnt_ff;
    logic [15:0]          rb_ff;
    logic [15:0]          clr_code_ff;
    logic [3:0]           clr_en_ff;
    logic [3:0][15:0]     in_ff;
    logic [3:0]           pend_ff;
    logic                 frame_err_ff;
    logic [15:0]          idle_ff;

    // All checks run on the core clock and sleep in reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Pin order in the synchroniser bundle
    assign pins = {over_temp, short_circuit, open_circuit, board_address_bit1,
                   board_address_bit0, clear_in, load_outputs_n, serial_in,
                   serial_clk, frame_sync_n};

    // Reset levels match idle pins, so no false edge follows reset
    dslc_sync #(.W(NS), .RV(dslc_pkg::PIN_RST)) dslc_sync_i (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .pin_in   (pins),
        .lvl_out  (lvl)
    );

    // Clean levels and their edges, the edges gated by the enable
    wire sync_n_l  = lvl[0];
    wire sdi_l     = lvl[2];
    wire load_l    = lvl[3];
    wire clr_l     = lvl[4];
    wire [1:0] brd = lvl[6:5];
    wire sclk_fall = ce & lvl_d_ff[1] & ~lvl[1];
    wire sclk_rise = ce & ~lvl_d_ff[1] & lvl[1];
    wire frm_start = ce & lvl_d_ff[0] & ~sync_n_l;
    wire frm_end   = ce & ~lvl_d_ff[0] & sync_n_l;
    wire load_fall = ce & lvl_d_ff[3] & ~load_l;
    wire clr_rise  = ce & ~lvl_d_ff[4] & clr_l;
    wire activity  = ce & (lvl_d_ff[2:0] != lvl[2:0]);

    // Frame fields; a short or long frame is an error and writes nothing
    wire       full     = (cnt_ff == 5'(dslc_pkg::FRAME_BITS));
    wire [1:0] f_addr   = shreg_ff[dslc_pkg::ADDR_HI:dslc_pkg::ADDR_LO];
    wire [1:0] f_cmd    = shreg_ff[dslc_pkg::CMD_HI:dslc_pkg::CMD_LO];
    wire [1:0] f_ch     = shreg_ff[dslc_pkg::CH_HI:dslc_pkg::CH_LO];
    wire [15:0] f_data  = shreg_ff[dslc_pkg::DATA_HI:0];
    wire       addr_ok  = (f_addr == brd);
    wire       good     = frm_end & full & addr_ok;
    wire       bad_end  = frm_end & ~full;

    // Decode of a command in a finished good frame
    function automatic logic cmd_hit(input logic ok, input logic [1:0] c,
                                     input dslc_pkg::dslc_cmd_t want);
        cmd_hit = ok & (c == want);
    endfunction : cmd_hit

    wire wr_data = cmd_hit(good, f_cmd, dslc_pkg::CMD_DATA);
    wire wr_ccod = cmd_hit(good, f_cmd, dslc_pkg::CMD_CLR_CODE);
    wire wr_cen  = cmd_hit(good, f_cmd, dslc_pkg::CMD_CLR_EN);
    wire rd_req  = cmd_hit(good, f_cmd, dslc_pkg::CMD_READ);

    // Frame state: shifting only between frame start and end
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            dslc_pkg::ST_IDLE:  if (frm_start) nxt_st = dslc_pkg::ST_SHIFT;
            dslc_pkg::ST_SHIFT: if (frm_end) nxt_st = dslc_pkg::ST_IDLE;
            default:            nxt_st = dslc_pkg::ST_IDLE;
        endcase
    end

    wire shifting = (st_ff == dslc_pkg::ST_SHIFT) & ~sync_n_l;
    wire take_bit = shifting & sclk_fall;
    wire [4:0] nxt_cnt = full ? cnt_ff : cnt_ff + 5'h01;

    // Previous levels for edge finding
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) lvl_d_ff <= dslc_pkg::PIN_RST;
        else if (ce) lvl_d_ff <= lvl;
    end

    // Shift register and bit count; count saturates one past a frame
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff    <= dslc_pkg::ST_IDLE;
            shreg_ff <= 24'h000000;
            cnt_ff   <= 5'h00;
        end else if (ce) begin
            st_ff <= nxt_st;
            if (frm_start) cnt_ff <= 5'h00;
            else if (take_bit) begin
                shreg_ff <= {shreg_ff[22:0], sdi_l};
                cnt_ff   <= (cnt_ff > 5'(dslc_pkg::FRAME_BITS)) ? cnt_ff : nxt_cnt + 5'(full);
            end
        end
    end

    // Readback word, shifted on rising serial clock during the next frame
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) rb_ff <= 16'h0000;
        else if (rd_req) rb_ff <= dac_code[f_ch];
        else if (shifting & sclk_rise) rb_ff <= {rb_ff[14:0], 1'b0};
    end

    // Output pin driven only inside a frame
    assign serial_out    = rb_ff[15];
    assign serial_out_oe = ~sync_n_l;

    // Clear code and per-channel clear enables
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_code_ff <= dslc_pkg::CLR_CODE_RST;
            clr_en_ff   <= dslc_pkg::CLR_EN_RST;
        end else begin
            if (wr_ccod) clr_code_ff <= f_data;
            if (wr_cen) clr_en_ff <= f_data[3:0];
        end
    end

    // Per-channel registers; a clear edge on an enabled channel outranks any output write
    for (genvar i = 0; i < 4; i++) begin : g_ch
        wire hit    = wr_data & (f_ch == 2'(i));
        wire direct = hit & ~load_l & ~clr_l;
        wire stage  = hit & load_l;
        wire moved  = load_fall & ~clr_l & pend_ff[i];
        wire force0 = clr_rise & clr_en_ff[i];

        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                in_ff[i]    <= dslc_pkg::CODE_RST;
                dac_code[i] <= dslc_pkg::CODE_RST;
                pend_ff[i]  <= 1'b0;
            end else begin
                if (hit) in_ff[i] <= f_data;
                if (force0) dac_code[i] <= clr_code_ff;
                else if (direct) dac_code[i] <= f_data;
                else if (moved) dac_code[i] <= in_ff[i];
                if (stage) pend_ff[i] <= 1'b1;
                else if (moved | direct) pend_ff[i] <= 1'b0;
            end
        end

        // Staged write reaches output one cycle after the load edge
        load_move_a: assert property (moved |=> dac_code[i] == $past(in_ff[i]))
            else $error("pending code not moved on load edge");
        clr_hold_a: assert property (clr_rise & ~clr_en_ff[i] & ~direct & ~moved
                                     |=> $stable(dac_code[i]))
            else $error("clear changed a channel that is not enabled");
    end

    // Frame error flag, cleared by the next full-length frame for any board; set wins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) frame_err_ff <= 1'b0;
        else if (bad_end) frame_err_ff <= 1'b1;
        else if (frm_end & full) frame_err_ff <= 1'b0;
    end

    // Open-drain fault: drive low while any fault stands
    assign fault_n_o  = 1'b0;
    assign fault_n_oe = frame_err_ff | lvl[7] | lvl[8] | lvl[9];

    // Idle watchdog; a long count is a parameter for short simulations
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_ff <= 16'h0000;
            alert   <= 1'b0;
        end else if (ce) begin
            if (activity) begin
                idle_ff <= 16'h0000;
                alert   <= 1'b0;
            end else if (idle_ff == 16'(WDOG_CYC - 1)) alert <= 1'b1;
            else idle_ff <= idle_ff + 16'h0001;
        end
    end

    // Frame, readback, clear and status checks
    no_bits_idle_a: assert property (sync_n_l & ce |=> $stable(shreg_ff))
        else $error("shift register moved outside a frame");
    bit_take_a: assert property (take_bit |=> shreg_ff[0] == $past(sdi_l))
        else $error("input bit not captured on falling clock");
    rb_shift_a: assert property (shifting & sclk_rise & ~rd_req
                                 |=> serial_out == $past(rb_ff[14]))
        else $error("readback did not shift");
    direct_wr_a: assert property (g_ch[0].direct & ~g_ch[0].force0
                                  |=> dac_code[0] == $past(f_data))
        else $error("direct write missed at frame end");
    clr_block_a: assert property (clr_l & ~clr_rise |=> $stable(dac_code))
        else $error("output changed while clear active");
    clr_force_a: assert property (clr_rise & clr_en_ff[0]
                                  |=> dac_code[0] == $past(clr_code_ff))
        else $error("clear code not applied");
    wrong_brd_a: assert property (frm_end & ~addr_ok |=> $stable(in_ff))
        else $error("frame for another board was taken");
    alert_clr_a: assert property (activity |=> !alert)
        else $error("alert stayed after activity");
    fault_pin_a: assert property (bad_end |=> ##[0:1] fault_n_oe)
        else $error("frame error did not pull fault low");

    frame_c: cover property (good ##[1:100] frm_end);
    load_c: cover property (load_fall & |pend_ff);
    clear_c: cover property (clr_rise & |clr_en_ff);
    alert_c: cover property ($rose(alert));
endmodule : dslc_port

// ==== tb/dslc_host.sv ====
/*
 Host-side serial master for the load and clear port: frames 24-bit words
 MSB first and collects readback bits from the serial output.
 Assumes the caller starts a frame only after the previous one has ended.
*/
`timescale 1ns/1ns
module dslc_host (
    // Serial link pins towards the port
    output logic        frame_sync_n,
    output logic        serial_clk,
    output logic        serial_in,
    // Readback pin from the port
    input  wire logic   serial_out
);
    logic [15:0] rd_bits;

    // Idle link: frame high, clock parked high and still
    initial begin
        frame_sync_n = 1'b1;
        serial_clk   = 1'b1;
        serial_in    = 1'b0;
        rd_bits      = 16'h0000;
    end

    // One frame; readback sampled late in each of the first 16 low phases, well after it moved
    task automatic send(input logic [23:0] word, input int nbits);
        #7;
        frame_sync_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_in = word[23 - i];
            #160 serial_clk = 1'b0;
            #160;
            if (i < 16) begin
                rd_bits[15 - i] = serial_out;
            end
            serial_clk = 1'b1;
        end
        #160 frame_sync_n = 1'b1;
        // Released data line must not keep showing the last bit
        serial_in = ~serial_in;
        #400;
    endtask : send
endmodule : dslc_host

// ==== tb/dslc_port_bench.sv ====
/*
 Self-checking bench for the serial load and clear port with a host model.
 Assumes the short idle-alert count below and a 25 MHz core clock.
*/
`timescale 1ns/1ns
module dslc_port_bench;
    localparam int unsigned WDC = 50;
    logic             core_clk, rst_b, ce, frame_sync_n, serial_clk, serial_in;
    logic             serial_out, serial_out_oe, load_outputs_n, clear_in;
    logic             board_address_bit0, board_address_bit1, alert, fault_n_o;
    logic             open_circuit, short_circuit, over_temp, fault_n_oe;
    logic [3:0][15:0] dac_code;
    logic [15:0]      exp_out [4];
    logic [15:0]      d0, d2, cc;
    logic [1:0]       badr;
    int               error_cnt, check_count, ch;

    dslc_port #(.WDOG_CYC(WDC)) dslc_port_i (
        .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .frame_sync_n(frame_sync_n),
        .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .load_outputs_n(load_outputs_n),
        .clear_in(clear_in), .board_address_bit0(board_address_bit0),
        .board_address_bit1(board_address_bit1), .open_circuit(open_circuit),
        .short_circuit(short_circuit), .over_temp(over_temp), .alert(alert),
        .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .dac_code(dac_code));

    dslc_host dslc_host_i (.frame_sync_n(frame_sync_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out));

    // Core clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t code got %h exp %h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    // Frame word: board address, command, channel, two spare bits, code
    function automatic logic [23:0] mk(input logic [1:0] a, input dslc_pkg::dslc_cmd_t c,
                                       input int k, input logic [15:0] d);
        return {a, c, 2'(k), 2'b00, d};
    endfunction : mk

    task automatic frame(input logic [23:0] w, input int nbits);
        @(negedge core_clk);
        dslc_host_i.send(w, nbits);
        cyc(8);
    endtask : frame

    task automatic chk_all();
        for (int k = 0; k < 4; k++) begin
            chk_code(dac_code[k], exp_out[k]);
        end
    endtask : chk_all

    // Hang guard, far beyond the expected run
    initial begin
        #2_000_000;
        error_cnt++;
        summarize();
    end

    // Main sequence
    initial begin
        error_cnt = 0;
        check_count = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        load_outputs_n = 1'b0;
        clear_in = 1'b0;
        {open_circuit, short_circuit, over_temp} = 3'h0;
        void'($urandom(89));
        badr = 2'($urandom);
        {board_address_bit1, board_address_bit0} = badr;
        for (int k = 0; k < 4; k++) exp_out[k] = dslc_pkg::CODE_RST;
        cyc(20);
        rst_b = 1'b1;
        cyc(6);
        chk_all();
        chk_bit(alert, 1'b0);
        chk_bit(fault_n_oe, 1'b0);
        chk_bit(serial_out_oe, 1'b0);
        // Direct writes with load held low, full scale on the last channel
        for (int k = 0; k < 4; k++) begin
            d0 = (k == 3) ? 16'hffff : 16'($urandom);
            frame(mk(badr, dslc_pkg::CMD_DATA, k, d0), 24);
            exp_out[k] = d0;
            chk_all();
        end
        frame(mk(~badr, dslc_pkg::CMD_DATA, 1, 16'h5a5a), 24);
        chk_all();
        // Staged writes, then one load edge moves both together
        load_outputs_n = 1'b1;
        d0 = ~exp_out[0];
        d2 = ~exp_out[2];
        frame(mk(badr, dslc_pkg::CMD_DATA, 0, d0), 24);
        frame(mk(badr, dslc_pkg::CMD_DATA, 2, d2), 24);
        chk_all();
        load_outputs_n = 1'b0;
        for (int k = 0; k < 10; k++) begin
            cyc(1);
            chk_bit(dac_code[0] === d0, dac_code[2] === d2);
        end
        exp_out[0] = d0;
        exp_out[2] = d2;
        chk_all();
        // Clear code and enables for channels 0 and 2 only
        cc = 16'($urandom);
        frame(mk(badr, dslc_pkg::CMD_CLR_CODE, 0, cc), 24);
        frame(mk(badr, dslc_pkg::CMD_CLR_EN, 0, 16'h0005), 24);
        chk_all();
        clear_in = 1'b1;
        cyc(8);
        exp_out[0] = cc;
        exp_out[2] = cc;
        chk_all();
        frame(mk(badr, dslc_pkg::CMD_DATA, 1, ~cc), 24);
        chk_all();
        clear_in = 1'b0;
        cyc(4);
        // Readback of a random channel in the following frame
        ch = $urandom % 4;
        frame(mk(badr, dslc_pkg::CMD_READ, ch, 16'h0000), 24);
        @(negedge core_clk);
        fork
            dslc_host_i.send(mk(badr, dslc_pkg::CMD_READ, ch, 16'h0000), 24);
            begin
                cyc(12);
                chk_bit(serial_out_oe, 1'b1);
            end
        join
        cyc(8);
        chk_code(dslc_host_i.rd_bits, exp_out[ch]);
        // Short frame writes nothing and raises the fault
        frame(mk(badr, dslc_pkg::CMD_DATA, 3, 16'h1234), 23);
        chk_bit(fault_n_oe, 1'b1);
        chk_bit(fault_n_o, 1'b0);
        chk_all();
        frame(mk(badr, dslc_pkg::CMD_DATA, 3, 16'h1234), 24);
        exp_out[3] = 16'h1234;
        chk_bit(fault_n_oe, 1'b0);
        chk_all();
        // Enable low freezes the port: a whole frame goes unseen
        ce = 1'b0;
        frame(mk(badr, dslc_pkg::CMD_DATA, 3, 16'hbeef), 24);
        ce = 1'b1;
        cyc(8);
        chk_all();
        // Each monitor on its own
        for (int k = 0; k < 3; k++) begin
            {over_temp, short_circuit, open_circuit} = 3'h1 << k;
            cyc(8);
            chk_bit(fault_n_oe, 1'b1);
            {over_temp, short_circuit, open_circuit} = 3'h0;
            cyc(8);
            chk_bit(fault_n_oe, 1'b0);
        end
        // Idle alert: not yet, then raised, then dropped by traffic
        frame(mk(badr, dslc_pkg::CMD_CLR_EN, 0, 16'h0005), 24);
        cyc(20);
        chk_bit(alert, 1'b0);
        cyc(30);
        chk_bit(alert, 1'b1);
        frame(mk(badr, dslc_pkg::CMD_CLR_EN, 0, 16'h0005), 24);
        chk_bit(alert, 1'b0);
        // Reset in mid-run, then the port works again
        rst_b = 1'b0;
        cyc(2);
        for (int k = 0; k < 4; k++) exp_out[k] = dslc_pkg::CODE_RST;
        chk_all();
        rst_b = 1'b1;
        cyc(6);
        frame(mk(badr, dslc_pkg::CMD_DATA, 2, 16'h8001), 24);
        exp_out[2] = 16'h8001;
        chk_all();
        summarize();
    end
endmodule : dslc_port_bench
